// ==== inc/scc_pkg.sv ====
// Package for the sink current control block: register map, fields, resets
// Assumes a 32-bit AXI4-Lite register bus with word-aligned registers
package scc_pkg;

    // Register byte offsets
    localparam logic [3:0] ENSW_OFS   = 4'h0;
    localparam logic [3:0] LEVEL0_OFS = 4'h4;
    localparam logic [3:0] LEVEL1_OFS = 4'h8;

    // Enable/switch register fields
    localparam int GEN_EN_BIT  = 7;
    localparam int CH1_SW_BIT  = 1;
    localparam int CH0_SW_BIT  = 0;

    // Level register fields
    localparam int STAGE_BIT   = 4;
    localparam int CODE_MSB    = 3;
    localparam int CODE_LSB    = 0;

    // Reset values of the implemented fields
    localparam logic       GEN_EN_RST = 1'b0;
    localparam logic [1:0] SW_RST     = 2'h0;
    localparam logic       STAGE_RST  = 1'b0;
    localparam logic [3:0] CODE_RST   = 4'h0;

    // Current law, in mA
    localparam logic [7:0] FINE_BASE_MA   = 8'h01;
    localparam logic [7:0] FINE_STEP_MA   = 8'h01;
    localparam logic [7:0] COARSE_BASE_MA = 8'h1b;
    localparam logic [7:0] COARSE_STEP_MA = 8'h0b;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : scc_pkg

// ==== src/scc_sink_current_control.sv ====
// Sink current control: AXI4-Lite registers driving two sink channel codes
// Assumes clk_i at 125 MHz, synchronous active-high reset, analog cells
// outside take the commanded current in mA and the drive flags.
`timescale 1ns/100ps
module scc_sink_current_control (
    input  wire logic        clk_i,          // System clock, 125 MHz
    input  wire logic        sys_rst_i,      // Synchronous reset, active high
    input  wire logic [3:0]  s_awaddr_i,     // Write address
    input  wire logic        s_awvalid_i,    // Write address valid
    output logic             s_awready_o,    // Write address ready
    input  wire logic [31:0] s_wdata_i,      // Write data
    input  wire logic [3:0]  s_wstrb_i,      // Write byte strobes
    input  wire logic        s_wvalid_i,     // Write data valid
    output logic             s_wready_o,     // Write data ready
    output logic [1:0]       s_bresp_o,      // Write response
    output logic             s_bvalid_o,     // Write response valid
    input  wire logic        s_bready_i,     // Write response ready
    input  wire logic [3:0]  s_araddr_i,     // Read address
    input  wire logic        s_arvalid_i,    // Read address valid
    output logic             s_arready_o,    // Read address ready
    output logic [31:0]      s_rdata_o,      // Read data
    output logic [1:0]       s_rresp_o,      // Read response
    output logic             s_rvalid_o,     // Read data valid
    input  wire logic        s_rready_i,     // Read data ready
    output logic [7:0]       sink_output_0_ma_o, // Sink 0 current, mA
    output logic [7:0]       sink_output_1_ma_o, // Sink 1 current, mA
    output logic [1:0]       sink_drive_o    // Per-sink drive; 0 = floating
);

    logic        generator_enable_reg;
    logic [1:0]  channel_switch_reg;
    logic [1:0]  stage_select_reg;
    logic [3:0]  level_code_reg [2];
    logic        aw_held_reg;
    logic        w_held_reg;
    logic [3:0]  awaddr_reg;
    logic [31:0] wdata_reg;
    logic        wstrb0_reg;
    logic        wr_go;
    logic [7:0]  ma_next [2];
    logic [7:0]  ma_reg [2];
    logic [1:0]  drive_reg;
    logic [7:0]  rd_byte;
    logic        rd_hit;

    // Write channel capture: address and data accepted in either order
    assign wr_go       = aw_held_reg && w_held_reg && !s_bvalid_o;

    // Ready flags: low from a take until the matching response is taken
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            s_awready_o <= 1'b1;
            s_wready_o  <= 1'b1;
            s_arready_o <= 1'b1;
        end else begin
            if (s_awvalid_i && s_awready_o) begin
                s_awready_o <= 1'b0;
            end else if (s_bvalid_o && s_bready_i) begin
                s_awready_o <= 1'b1;
            end
            if (s_wvalid_i && s_wready_o) begin
                s_wready_o <= 1'b0;
            end else if (s_bvalid_o && s_bready_i) begin
                s_wready_o <= 1'b1;
            end
            if (s_arvalid_i && s_arready_o) begin
                s_arready_o <= 1'b0;
            end else if (s_rvalid_o && s_rready_i) begin
                s_arready_o <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            awaddr_reg  <= 4'h0;
            wdata_reg   <= 32'h0;
            wstrb0_reg  <= 1'b0;
        end else begin
            if (s_awvalid_i && s_awready_o) begin
                aw_held_reg <= 1'b1;
                awaddr_reg  <= s_awaddr_i;
            end else if (wr_go) begin
                aw_held_reg <= 1'b0;
            end
            if (s_wvalid_i && s_wready_o) begin
                w_held_reg <= 1'b1;
                wdata_reg  <= s_wdata_i;
                wstrb0_reg <= s_wstrb_i[0];
            end else if (wr_go) begin
                w_held_reg <= 1'b0;
            end
        end
    end

    // Write response; unmapped address answers SLVERR
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            s_bvalid_o <= 1'b0;
            s_bresp_o  <= scc_pkg::RESP_OKAY;
        end else if (wr_go) begin
            s_bvalid_o <= 1'b1;
            s_bresp_o  <= (awaddr_reg == scc_pkg::ENSW_OFS ||
                           awaddr_reg == scc_pkg::LEVEL0_OFS ||
                           awaddr_reg == scc_pkg::LEVEL1_OFS)
                          ? scc_pkg::RESP_OKAY : scc_pkg::RESP_SLVERR;
        end else if (s_bvalid_o && s_bready_i) begin
            s_bvalid_o <= 1'b0;
        end
    end

    // Control registers, written through byte lane 0
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            generator_enable_reg <= scc_pkg::GEN_EN_RST;
            channel_switch_reg   <= scc_pkg::SW_RST;
        end else if (wr_go && wstrb0_reg &&
                     awaddr_reg == scc_pkg::ENSW_OFS) begin
            generator_enable_reg <= wdata_reg[scc_pkg::GEN_EN_BIT];
            channel_switch_reg   <= {wdata_reg[scc_pkg::CH1_SW_BIT],
                                     wdata_reg[scc_pkg::CH0_SW_BIT]};
        end
    end

    // Per-channel level registers
    for (genvar ch = 0; ch < 2; ch++) begin : g_level
        localparam logic [3:0] OFS = (ch == 0) ? scc_pkg::LEVEL0_OFS
                                               : scc_pkg::LEVEL1_OFS;
        always_ff @(posedge clk_i) begin
            if (sys_rst_i) begin
                stage_select_reg[ch] <= scc_pkg::STAGE_RST;
                level_code_reg[ch]   <= scc_pkg::CODE_RST;
            end else if (wr_go && wstrb0_reg && awaddr_reg == OFS) begin
                stage_select_reg[ch] <= wdata_reg[scc_pkg::STAGE_BIT];
                level_code_reg[ch]   <=
                    wdata_reg[scc_pkg::CODE_MSB:scc_pkg::CODE_LSB];
            end
        end

        // Current law, gated by enable and switch
        always_comb begin
            if (!(generator_enable_reg && channel_switch_reg[ch])) begin
                ma_next[ch] = 8'h00;
            end else if (stage_select_reg[ch]) begin
                ma_next[ch] = 8'(scc_pkg::COARSE_BASE_MA +
                    scc_pkg::COARSE_STEP_MA * {4'h0, level_code_reg[ch]});
            end else begin
                ma_next[ch] = 8'(scc_pkg::FINE_BASE_MA +
                    scc_pkg::FINE_STEP_MA * {4'h0, level_code_reg[ch]});
            end
        end

        always_ff @(posedge clk_i) begin
            if (sys_rst_i) begin
                ma_reg[ch]    <= 8'h00;
                drive_reg[ch] <= 1'b0;
            end else begin
                ma_reg[ch]    <= ma_next[ch];
                drive_reg[ch] <= generator_enable_reg &&
                                 channel_switch_reg[ch];
            end
        end
    end

    assign sink_output_0_ma_o = ma_reg[0];
    assign sink_output_1_ma_o = ma_reg[1];
    assign sink_drive_o       = drive_reg;

    // Read mux; unimplemented bits read zero
    always_comb begin
        rd_byte = 8'h00;
        rd_hit  = 1'b1;
        case (s_araddr_i)
            scc_pkg::ENSW_OFS: begin
                rd_byte[scc_pkg::GEN_EN_BIT] = generator_enable_reg;
                rd_byte[scc_pkg::CH1_SW_BIT] = channel_switch_reg[1];
                rd_byte[scc_pkg::CH0_SW_BIT] = channel_switch_reg[0];
            end
            scc_pkg::LEVEL0_OFS: begin
                rd_byte = {3'h0, stage_select_reg[0], level_code_reg[0]};
            end
            scc_pkg::LEVEL1_OFS: begin
                rd_byte = {3'h0, stage_select_reg[1], level_code_reg[1]};
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // Read channel: one read in flight
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            s_rvalid_o <= 1'b0;
            s_rdata_o  <= 32'h0;
            s_rresp_o  <= scc_pkg::RESP_OKAY;
        end else if (s_arvalid_i && s_arready_o) begin
            s_rvalid_o <= 1'b1;
            s_rdata_o  <= {24'h0, rd_byte};
            s_rresp_o  <= rd_hit ? scc_pkg::RESP_OKAY : scc_pkg::RESP_SLVERR;
        end else if (s_rvalid_o && s_rready_i) begin
            s_rvalid_o <= 1'b0;
        end
    end

    // Disabled generator leaves both sinks idle two cycles later
    gen_off_idle_a: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        !generator_enable_reg ##1 !generator_enable_reg |=>
        sink_drive_o == 2'h0 && sink_output_0_ma_o == 8'h00 &&
        sink_output_1_ma_o == 8'h00)
        else $error("Sink active while generator disabled");

    // Coarse stage law on channel 1
    coarse_law_a: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        generator_enable_reg && channel_switch_reg[1] && stage_select_reg[1]
        |=> sink_output_1_ma_o ==
            8'(8'h1b + 8'h0b * $past({4'h0, level_code_reg[1]})))
        else $error("Coarse stage current wrong");

    // Fine stage law on channel 0
    fine_law_a: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        generator_enable_reg && channel_switch_reg[0] && !stage_select_reg[0]
        |=> sink_output_0_ma_o ==
            8'(8'h01 + $past({4'h0, level_code_reg[0]})))
        else $error("Fine stage current wrong");

    // Channel 1 switch off commands zero current
    switch_off_zero_a: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        !channel_switch_reg[1] |=> !sink_drive_o[1] &&
        sink_output_1_ma_o == 8'h00)
        else $error("Channel driven with switch off");

    // Read data upper bits stay zero
    read_zero_bits_a: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        s_rvalid_o |-> s_rdata_o[31:8] == 24'h0 &&
        (s_rresp_o != scc_pkg::RESP_OKAY || s_rdata_o[7:5] == 3'h0 ||
         s_rdata_o[6:2] == 5'h0))
        else $error("Unimplemented bits read non-zero");

    // Write to enable register updates it next cycle
    enable_write_a: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        wr_go && wstrb0_reg && awaddr_reg == scc_pkg::ENSW_OFS |=>
        generator_enable_reg == $past(wdata_reg[7]) &&
        channel_switch_reg == $past(wdata_reg[1:0]))
        else $error("Enable/switch write lost");

    // Level 0 write stores stage and code
    level_write_a: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        wr_go && wstrb0_reg && awaddr_reg == scc_pkg::LEVEL0_OFS |=>
        {stage_select_reg[0], level_code_reg[0]} == $past(wdata_reg[4:0]))
        else $error("Level write lost");

    // Controls are zero right after reset
    reset_zero_a: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        $past(sys_rst_i) |-> !generator_enable_reg &&
        channel_switch_reg == 2'h0 && stage_select_reg == 2'h0 &&
        level_code_reg[0] == 4'h0 && level_code_reg[1] == 4'h0)
        else $error("Control bits not zero after reset");

endmodule : scc_sink_current_control

// ==== tb/tb.sv ====
// Testbench for the sink current control block: AXI4-Lite register traffic
// Assumes a 125 MHz clock, synchronous active-high reset, byte offsets 0/4/8
`timescale 1ns/100ps
module tb;
    logic        clk_i;
    logic        sys_rst_i;
    logic [3:0]  s_awaddr_i, s_araddr_i, s_wstrb_i;
    logic [31:0] s_wdata_i;
    logic        s_awvalid_i, s_wvalid_i, s_bready_i, s_arvalid_i, s_rready_i;
    logic        s_awready_o, s_wready_o, s_bvalid_o, s_arready_o, s_rvalid_o;
    logic [1:0]  s_bresp_o, s_rresp_o, sink_drive_o;
    logic [31:0] s_rdata_o;
    logic [7:0]  sink_output_0_ma_o, sink_output_1_ma_o;
    int          failures, total_checks;
    logic [31:0] rd;
    logic [1:0]  rsp;
    logic        en;
    logic [1:0]  sw;
    logic [4:0]  lv0, lv1;

    scc_sink_current_control scc_sink_current_control_i (
        .clk_i              (clk_i),
        .sys_rst_i          (sys_rst_i),
        .s_awaddr_i         (s_awaddr_i),
        .s_awvalid_i        (s_awvalid_i),
        .s_awready_o        (s_awready_o),
        .s_wdata_i          (s_wdata_i),
        .s_wstrb_i          (s_wstrb_i),
        .s_wvalid_i         (s_wvalid_i),
        .s_wready_o         (s_wready_o),
        .s_bresp_o          (s_bresp_o),
        .s_bvalid_o         (s_bvalid_o),
        .s_bready_i         (s_bready_i),
        .s_araddr_i         (s_araddr_i),
        .s_arvalid_i        (s_arvalid_i),
        .s_arready_o        (s_arready_o),
        .s_rdata_o          (s_rdata_o),
        .s_rresp_o          (s_rresp_o),
        .s_rvalid_o         (s_rvalid_o),
        .s_rready_i         (s_rready_i),
        .sink_output_0_ma_o (sink_output_0_ma_o),
        .sink_output_1_ma_o (sink_output_1_ma_o),
        .sink_drive_o       (sink_drive_o)
    );

    // Clock at 8 ns period
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    // Compare seen against expected and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Print counts and verdict, then stop
    task automatic test_done();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : test_done

    // One write: address and data offered together, bready held high
    task automatic axi_write(input logic [3:0] a, input logic [31:0] d,
                             input logic [3:0] st, output logic [1:0] r);
        @(posedge clk_i);
        s_awaddr_i <= a; s_wdata_i <= d; s_wstrb_i <= st;
        s_awvalid_i <= 1'b1; s_wvalid_i <= 1'b1; s_bready_i <= 1'b1;
        for (int i = 0; i < 50; i++) begin
            @(posedge clk_i);
            if (s_awvalid_i && s_awready_o) s_awvalid_i <= 1'b0;
            if (s_wvalid_i && s_wready_o) s_wvalid_i <= 1'b0;
            if (s_bvalid_o) begin
                r = s_bresp_o;
                s_bready_i <= 1'b0;
                return;
            end
        end
        failures++;
        test_done();
    endtask : axi_write

    // One read: rready held high until rvalid is seen
    task automatic axi_read(input logic [3:0] a, output logic [31:0] d,
                            output logic [1:0] r);
        @(posedge clk_i);
        s_araddr_i <= a; s_arvalid_i <= 1'b1; s_rready_i <= 1'b1;
        for (int i = 0; i < 50; i++) begin
            @(posedge clk_i);
            if (s_arvalid_i && s_arready_o) s_arvalid_i <= 1'b0;
            if (s_rvalid_o) begin
                d = s_rdata_o;
                r = s_rresp_o;
                s_rready_i <= 1'b0;
                return;
            end
        end
        failures++;
        test_done();
    endtask : axi_read

    // Commanded current of one channel from its settings
    function automatic logic [7:0] exp_ma(input logic on, input logic [4:0] l);
        if (!on) return 8'h00;
        if (l[4]) return 8'h1b + 8'h0b * {4'h0, l[3:0]};
        return 8'h01 + {4'h0, l[3:0]};
    endfunction : exp_ma

    // Read a register and compare data and response
    task automatic read_chk(input logic [3:0] a, input logic [31:0] e);
        axi_read(a, rd, rsp);
        check(rd, e);
        check({30'h0, rsp}, {30'h0, scc_pkg::RESP_OKAY});
    endtask : read_chk

    initial begin
        sys_rst_i = 1'b1; s_awaddr_i = 4'h0; s_araddr_i = 4'h0;
        s_wstrb_i = 4'h0; s_wdata_i = 32'h0; s_awvalid_i = 1'b0;
        s_wvalid_i = 1'b0; s_bready_i = 1'b0; s_arvalid_i = 1'b0;
        s_rready_i = 1'b0; failures = 0; total_checks = 0;
        void'($urandom(51936));
        repeat (3) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        // Reset values of all registers and outputs
        read_chk(4'h0, 32'h0);
        read_chk(4'h4, 32'h0);
        read_chk(4'h8, 32'h0);
        check({14'h0, sink_drive_o, sink_output_1_ma_o,
               sink_output_0_ma_o}, 32'h0);
        // All ones: unimplemented bits read back as zero
        axi_write(4'h0, 32'hffffffff, 4'hf, rsp);
        read_chk(4'h0, 32'h83);
        axi_write(4'h4, 32'hffffffff, 4'hf, rsp);
        read_chk(4'h4, 32'h1f);
        // Lane 0 strobe off: write ignored
        axi_write(4'h4, 32'h00, 4'he, rsp);
        read_chk(4'h4, 32'h1f);
        // Unmapped address: error response, read as zero
        axi_write(4'hc, 32'hff, 4'hf, rsp);
        check({30'h0, rsp}, {30'h0, scc_pkg::RESP_SLVERR});
        axi_read(4'hc, rd, rsp);
        check(rd, 32'h0);
        check({30'h0, rsp}, {30'h0, scc_pkg::RESP_SLVERR});
        // Random settings with code and stage corners first
        for (int i = 0; i < 40; i++) begin
            en = (i < 4) ? 1'b1 : 1'($urandom);
            sw = (i < 4) ? 2'h3 : 2'($urandom);
            lv0 = (i == 0) ? 5'h00 : (i == 1) ? 5'h1f : 5'($urandom);
            lv1 = (i == 0) ? 5'h1f : (i == 1) ? 5'h10 : 5'($urandom);
            if (i == 2) lv0 = 5'h0f;
            // Shared-pin case: level cleared while its switch is off
            if (i[0] && !sw[0]) lv0 = 5'h00;
            if (i[0] && !sw[1]) lv1 = 5'h00;
            axi_write(4'h0, {$urandom} & 32'hffffff7c | {en, 5'h0, sw},
                      4'hf, rsp);
            axi_write(4'h4, {$urandom} & 32'hffffffe0 | lv0, 4'hf, rsp);
            axi_write(4'h8, {$urandom} & 32'hffffffe0 | lv1, 4'hf, rsp);
            read_chk(4'h0, {24'h0, en, 5'h0, sw});
            read_chk(4'h8, {27'h0, lv1});
            read_chk(4'h4, {27'h0, lv0});
            repeat (2) @(posedge clk_i);
            #1;
            check({30'h0, sink_drive_o}, {30'h0, sw & {2{en}}});
            check({24'h0, sink_output_0_ma_o},
                  {24'h0, exp_ma(en & sw[0], lv0)});
            check({24'h0, sink_output_1_ma_o},
                  {24'h0, exp_ma(en & sw[1], lv1)});
        end
        test_done();
    end
endmodule : tb
